// ### qdac_device.sv
// qdac_device: device end, shift register, command decode, dac registers.
// assumes link pins asynchronous to clk_sys, sampled at 40 MHz.
module qdac_device (
  // system
  input wire logic clk_sys,
  input wire logic srst,
  // link
  qdac_link_if.dev link,
  // user side
  output logic [qdac_pkg::NUM_DACS*8-1:0] dac_code_value,
  output logic [qdac_pkg::NUM_DACS*8-1:0] input_code,
  output logic shutdown,
  output logic upo,
  output logic dout_phase
);
  logic [1:0] sclk_s, din_s, cs_s, ld_s;
  logic sclk_d, cs_d;
  logic [11:0] shreg;
  logic dout_r;
  logic rise, fall, cs_rise;
  logic [3:0] cmd;
  logic [7:0] data;

  // two-flop synchronisers; logic reads only the second stage
  always_ff @(posedge clk_sys) begin
    sclk_s <= {sclk_s[0], link.sclk};
    din_s <= {din_s[0], link.din};
    cs_s <= {cs_s[0], link.cs_n};
    ld_s <= {ld_s[0], link.load_outputs_n};
    sclk_d <= sclk_s[1];
    cs_d <= cs_s[1];
  end

  assign rise = sclk_s[1] & ~sclk_d & ~cs_s[1];
  assign fall = ~sclk_s[1] & sclk_d & ~cs_s[1];
  assign cs_rise = cs_s[1] & ~cs_d;
  assign cmd = shreg[qdac_pkg::CTRL_MSB:qdac_pkg::CTRL_LSB];
  assign data = shreg[qdac_pkg::DATA_BITS-1:0];
  assign link.dout = dout_r;  // always driven

  // shift in on rising edge, msb first
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      shreg <= 12'h000;
    end else if (rise) begin
      shreg <= {shreg[10:0], din_s[1]};
    end
  end

  // mode 0 updates on falling edge (11.5 lag), mode 1 on rising (12)
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      dout_r <= 1'b0;
    end else if (dout_phase ? rise : fall) begin
      dout_r <= shreg[11];  // holds while deselected
    end
  end

  // phase latch, default mode 0 after reset
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      dout_phase <= 1'b0;
    end else if (cs_rise && cmd == qdac_pkg::CMD_PHASE1) begin
      dout_phase <= 1'b1;
    end else if (cs_rise && cmd == qdac_pkg::CMD_PHASE0) begin
      dout_phase <= 1'b0;
    end
  end

  // commit on chip select rise pass command touches nothing
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      input_code <= '0;
      dac_code_value <= '0;
      shutdown <= 1'b0;
      upo <= 1'b0;
    end else begin
      if (cs_rise) begin
        case (cmd)
          qdac_pkg::CMD_PASS: begin
          end
          qdac_pkg::CMD_UPO_LOW: upo <= 1'b0;
          qdac_pkg::CMD_UPO_HIGH: upo <= 1'b1;
          qdac_pkg::CMD_SHUTDOWN: shutdown <= 1'b1;
          qdac_pkg::CMD_LOAD_ALL_SR: begin
            dac_code_value <= {qdac_pkg::NUM_DACS{data}};  // straight binary
            shutdown <= 1'b0;
          end
          qdac_pkg::CMD_UPDATE: begin
            dac_code_value <= input_code;
            shutdown <= 1'b0;
          end
          qdac_pkg::CMD_PHASE0, qdac_pkg::CMD_PHASE1: dac_code_value <= input_code;
          default: begin
            if (cmd[1:0] == qdac_pkg::CTRL_LOAD_IN || cmd[1:0] == qdac_pkg::CTRL_LOAD_UPD) begin
              input_code[cmd[3:2]*8 +: 8] <= data;
              if (cmd[1:0] == qdac_pkg::CTRL_LOAD_UPD || !ld_s[1]) begin
                dac_code_value <= input_code;
                dac_code_value[cmd[3:2]*8 +: 8] <= data;
              end
            end
          end
        endcase
      end else if (!ld_s[1]) begin
        dac_code_value <= input_code;  // load strobe updates all sharers
      end
    end
  end
endmodule : qdac_device

// ### qdac_host.sv
// qdac_host: host end, sends one 12*chain word per request.
// assumes requests come from logic on clk_sys.
module qdac_host #(
  parameter int CHAIN = 1
) (
  // system
  input wire logic clk_sys,
  input wire logic srst,
  // link
  qdac_link_if.host link,
  // user side
  input wire logic start,
  input wire logic [12*CHAIN-1:0] tx_word,
  input wire logic load_pulse,
  output logic busy,
  output logic [12*CHAIN-1:0] rx_word,
  output logic done
);
  localparam int TOTAL_BITS = 12 * CHAIN;
  qdac_pkg::qdac_host_state_t state;
  logic [TOTAL_BITS-1:0] sh;
  logic [15:0] bits;
  logic [7:0] div;
  logic [1:0] dout_s;
  logic sclk_r, cs_r, ld_r;

  assign link.sclk = sclk_r;
  // three plain lines plus load, no serial macro needed
  assign link.din = sh[TOTAL_BITS-1];  // msb first
  assign link.cs_n = cs_r;
  assign link.load_outputs_n = ld_r;
  assign busy = (state != qdac_pkg::QD_IDLE);

  // dout synchroniser
  always_ff @(posedge clk_sys) begin
    dout_s <= {dout_s[0], link.dout};
  end

  // load strobe, low one cycle for each idle cycle with load_pulse high
  always_ff @(posedge clk_sys) begin
    if (srst) ld_r <= 1'b1;
    else ld_r <= ~(load_pulse & ~busy);
  end

  // mode 0/0 framing, clock idles low and runs only in frames
  // polarity 1 is never used because dout is read back
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state <= qdac_pkg::QD_IDLE;
      sclk_r <= 1'b0;
      cs_r <= 1'b1;
      sh <= '0;
      rx_word <= '0;
      bits <= 16'h0000;
      div <= 8'h00;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state)
        qdac_pkg::QD_IDLE: begin
          sclk_r <= 1'b0;
          if (start) begin
            sh <= tx_word;
            cs_r <= 1'b0;
            bits <= 16'h0000;
            div <= 8'h00;
            state <= qdac_pkg::QD_LOW;
          end
        end
        qdac_pkg::QD_LOW: begin
          div <= div + 8'h01;
          if (div == 8'(qdac_pkg::SCLK_DIV - 1)) begin
            div <= 8'h00;
            sclk_r <= 1'b1;
            state <= qdac_pkg::QD_HIGH;
          end
        end
        qdac_pkg::QD_HIGH: begin
          div <= div + 8'h01;
          if (div == 8'(qdac_pkg::SCLK_DIV - 1)) begin
            div <= 8'h00;
            sclk_r <= 1'b0;
            // device output lags 12 per device in mode 0, 13 in mode 1; sampled at falling edge
            rx_word <= {rx_word[TOTAL_BITS-2:0], dout_s[1]};
            sh <= {sh[TOTAL_BITS-2:0], 1'b0};
            bits <= bits + 16'h0001;
            state <= (bits == 16'(TOTAL_BITS - 1)) ? qdac_pkg::QD_END : qdac_pkg::QD_LOW;
          end
        end
        qdac_pkg::QD_END: begin
          div <= div + 8'h01;
          if (div == 8'(qdac_pkg::SCLK_DIV - 1)) begin
            cs_r <= 1'b1;  // commit all chained devices at once
            done <= 1'b1;
            state <= qdac_pkg::QD_IDLE;
          end
        end
        default: state <= qdac_pkg::QD_IDLE;
      endcase
    end
  end
endmodule : qdac_host

// ### qdac_link_if.sv
// qdac_link_if: three-wire link plus load strobe and daisy output.
// assumes one host and one device instance joined by the bench.
interface qdac_link_if;
  logic sclk;
  logic din;
  logic cs_n;
  logic load_outputs_n;
  logic dout;
  modport host (output sclk, output din, output cs_n, output load_outputs_n, input dout);
  modport dev (input sclk, input din, input cs_n, input load_outputs_n, output dout);
endinterface : qdac_link_if

// ### qdac_link_properties.sv
// qdac_link_properties: link checks between host and device ends.
// assumes clk_sys samples the link; CHAIN matches the host.
module qdac_link_properties #(
  parameter int CHAIN = 1
) (
  // clock, reset
  input wire logic clk_sys,
  input wire logic srst,
  // link
  input wire logic sclk,
  input wire logic din,
  input wire logic cs_n,
  input wire logic load_outputs_n,
  input wire logic dout
);
  logic [15:0] n;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  // sclk rises in a frame; cleared while deselected
  always_ff @(posedge clk_sys) begin
    if (srst || cs_n) n <= 16'h0000;
    else if ($rose(sclk)) n <= n + 16'h0001;
  end
  sequence s_high4; sclk [*4] ##1 !sclk; endsequence
  sequence s_first; !sclk ##[1:8] $rose(sclk); endsequence
  a_sclk_half: assert property ($rose(sclk) |-> s_high4)
    else $error("sclk high time");
  a_idle_low: assert property (cs_n |-> !sclk)
    else $error("sclk not idle low");
  a_frame_bits: assert property ($rose(cs_n) |-> n == 16'(12 * CHAIN))
    else $error("frame bit count");
  a_dout_hold: assert property (cs_n && $past(cs_n, 4) |-> $stable(dout))
    else $error("dout moved when idle");
  a_frame_start: assert property ($fell(cs_n) |-> s_first)
    else $error("frame start");
  a_din_stable: assert property (sclk |-> $stable(din))
    else $error("din moved in high");
  a_load_pulse: assert property ($fell(load_outputs_n) |=> load_outputs_n)
    else $error("load strobe long");
  a_load_idle: assert property (!load_outputs_n |-> cs_n)
    else $error("load in frame");
endmodule : qdac_link_properties

// ### qdac_pkg.sv
// qdac_pkg: shared constants for the quad dac serial chain port.
// assumes both ends and the bench compile this first.
package qdac_pkg;
  localparam int WORD_BITS = 12;
  localparam int DATA_BITS = 8;
  localparam int CTRL_MSB = 11;
  localparam int CTRL_LSB = 8;
  localparam logic [3:0] CMD_PASS = 4'h0;  // pass_through_command
  localparam logic [3:0] CMD_UPO_LOW = 4'h2;
  localparam logic [3:0] CMD_UPO_HIGH = 4'h6;
  localparam logic [3:0] CMD_LOAD_ALL_SR = 4'h8;
  localparam logic [3:0] CMD_SHUTDOWN = 4'hC;
  localparam logic [3:0] CMD_UPDATE = 4'h4;
  localparam logic [3:0] CMD_PHASE1 = 4'hE;
  localparam logic [3:0] CMD_PHASE0 = 4'hA;
  localparam logic [1:0] CTRL_LOAD_IN = 2'h1;
  localparam logic [1:0] CTRL_LOAD_UPD = 2'h3;
  localparam int NUM_DACS = 4;
  localparam int SCLK_DIV = 4;  // half period in clk_sys cycles
  localparam logic [7:0] DAC_RESET = 8'h00;
  typedef enum logic [1:0] {QD_IDLE, QD_LOW, QD_HIGH, QD_END} qdac_host_state_t;
endpackage : qdac_pkg

// ### quad_dac_serial_chain_port_tb.sv
// quad_dac_serial_chain_port_tb: host and device joined, model compared.
// assumes package, interface, both ends and checker compile first.
module quad_dac_serial_chain_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic start = 1'b0;
  logic load_pulse = 1'b0;
  logic [23:0] tx_word = 24'h000000;
  logic [23:0] rx_word;
  logic [31:0] dac_code_value, input_code;
  logic done, shutdown, upo, dout_phase;
  logic [7:0] dac [4];
  logic [7:0] inr [4];
  logic [2:0] fl;
  logic [11:0] sr;
  logic h;  // dout level held from the previous frame
  int fail_count = 0;
  int checked = 0;
  qdac_link_if lk ();
  qdac_host #(.CHAIN(2)) qdac_host_inst (.clk_sys, .srst, .link(lk), .start, .tx_word,
    .load_pulse, .busy(), .rx_word, .done);
  qdac_device qdac_device_inst (.clk_sys, .srst, .link(lk), .dac_code_value,
    .input_code, .shutdown, .upo, .dout_phase);
  qdac_link_properties #(.CHAIN(2)) qdac_link_properties_inst (.clk_sys, .srst,
    .sclk(lk.sclk), .din(lk.din), .cs_n(lk.cs_n), .load_outputs_n(lk.load_outputs_n),
    .dout(lk.dout));
  // 25 ns system clock
  initial forever #12.5 clk_sys = ~clk_sys;
  task automatic chk(input string nm, input logic [66:0] e, input logic [66:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test
  // reset both ends and the model together; link idle until reset ends
  task automatic do_reset();
    srst <= 1'b1;
    repeat (5) @(posedge clk_sys);
    srst <= 1'b0;
    dac = '{default: 8'h00};
    inr = '{default: 8'h00};
    fl = 3'h0;
    sr = 12'h000;
    h = 1'b0;
  endtask : do_reset
  // one frame: upper word leaves on dout, lower word is decoded
  task automatic send(input logic [23:0] w);
    logic [3:0] c;
    c = w[11:8];
    start <= 1'b1;
    tx_word <= w;
    @(posedge clk_sys);
    start <= 1'b0;
    do @(negedge clk_sys); while (done !== 1'b1);
    repeat (6) @(posedge clk_sys); // commit trails cs_n through the sync
    // host samples at falling sclk through its sync, so mode 1 shows one bit later
    chk("rx_word", 67'(fl[0] ? {h, sr, w[23:13]} : {h, sr[10:0], w[23:12]}), 67'(rx_word));
    h = fl[0] ? w[12] : w[11];
    sr = w[11:0];
    if (c[0]) inr[c[3:2]] = w[7:0];
    if (c[1:0] == 2'h3 || c == 4'h4 || c == 4'hA || c == 4'hE) dac = inr;
    if (c == 4'h8) dac = '{default: w[7:0]};
    if (c == 4'h4 || c == 4'h8 || c == 4'hC) fl[2] = c[3] & c[2];
    if (c == 4'h2 || c == 4'h6) fl[1] = c[2];
    if (c == 4'hA || c == 4'hE) fl[0] = c[2];
    chk("regs", {dac[3], dac[2], dac[1], dac[0], inr[3], inr[2], inr[1], inr[0], fl},
      {dac_code_value, input_code, shutdown, upo, dout_phase});
  endtask : send
  initial begin
    void'($urandom(44831));
    do_reset();
    for (int i = 0; i < 16; i++) send({12'($urandom), 4'(i), 8'($urandom)});
    $display("command sweep over");
    send(24'h0001A5);
    load_pulse <= 1'b1;
    @(posedge clk_sys);
    load_pulse <= 1'b0;
    repeat (6) @(posedge clk_sys);
    dac = inr;
    send(24'h000000);
    $display("load strobe over");
    for (int i = 0; i < 20; i++) send(24'($urandom));
    $display("random frames over");
    do_reset();
    send(24'($urandom));
    $display("second reset over");
    finish_test();
  end
  // about 40 frames of 210 cycles; a wide margin over that
  initial begin
    #1ms;
    fail_count++;
    finish_test();
  end
endmodule : quad_dac_serial_chain_port_tb
